/* core/gate_ctrl_pkg.sv */
// Purpose: Shared constants and types for the inverter command controller
// Assumes: 200 MHz clock, 5 ns period
// Notes:   Times are kept in their printed units; cycle counts derive from them
package gate_ctrl_pkg;
    localparam int CLK_MHZ          = 200;               // Clock rate in MHz
    localparam int DEAD_NS          = 1500;              // Least dead time
    localparam int MIN_PULSE_NS     = 500;               // Least command pulse
    localparam int MIN_PERIOD_US    = 50;                // Carrier at most 20 kHz
    localparam int SD_LEVEL_NS      = 3000;              // Least shutdown level
    localparam int REACT_US         = 20;                // Silencing deadline budget
    localparam int RESTART_MS       = 2000;              // Least wait after a fault
    // Cycle counts, least times rounded up
    localparam int DEAD_CYC         = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_PULSE_CYC    = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_PERIOD_CYC   = MIN_PERIOD_US * CLK_MHZ;
    localparam int SD_LEVEL_CYC     = (SD_LEVEL_NS * CLK_MHZ + 999) / 1000;
    localparam int REACT_CYC        = REACT_US * CLK_MHZ;
    localparam longint RESTART_CYC  = longint'(RESTART_MS) * 1000 * CLK_MHZ;
    localparam int PHASES           = 3;                 // Inverter phases
    localparam int DUTY_W           = 16;                // Width of duty requests

    // Command pair of one phase set
    typedef struct packed {
        logic [PHASES-1:0] upper_switch_command;
        logic [PHASES-1:0] lower_switch_command;
    } gate_cmd_t;

    // Controller states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_RUN    = 4'b0010,
        ST_FAULT  = 4'b0100,
        ST_WAIT   = 4'b1000
    } ctrl_state_t;
endpackage : gate_ctrl_pkg

/* core/phase_pwm.sv */
// Purpose: One phase of complementary PWM with dead time and pulse floor
// Assumes: Shared carrier count from the parent, one clock
// Notes:   Both outputs low whenever enable is low
`timescale 1ns/100ps
`default_nettype none
module phase_pwm
    import gate_ctrl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             enable,
    input  wire logic [CNT_W-1:0] carrier,
    input  wire logic [CNT_W-1:0] duty,
    output logic                  upper_q,
    output logic                  lower_q
);
    logic [CNT_W-1:0] dead_q;            // Dead-time counter
    logic [CNT_W-1:0] hold_q;            // Pulse-width counter
    logic             want_up;           // Raw comparator, high side wanted
    logic             busy;              // Any timer still running
    logic             cur_up;            // Present high-side state
    logic             change;            // Requested state differs

    assign want_up = enable && (carrier < duty);
    assign busy    = (dead_q != '0) || (hold_q != '0);
    assign cur_up  = upper_q;
    assign change  = (want_up != cur_up) || (!want_up && !lower_q && enable);

    // Switch only after both timers expire; off edge starts dead time
    always_ff @(posedge clock) begin
        if (!rst_b || !enable) begin
            upper_q <= 1'b0;                                  // [R22]
            lower_q <= 1'b0;
            dead_q  <= CNT_W'(DEAD_CYC);
            hold_q  <= '0;
        end else if (upper_q || lower_q) begin
            if (hold_q != '0) begin
                hold_q <= hold_q - 1'b1;                      // [R3]
            end else if (change) begin
                upper_q <= 1'b0;                              // Both off first [R22]
                lower_q <= 1'b0;
                dead_q  <= CNT_W'(DEAD_CYC);                  // [R2]
            end
        end else if (dead_q != '0) begin
            dead_q <= dead_q - 1'b1;                          // [R2]
        end else if (!busy) begin
            upper_q <= want_up;                               // Only one side at once [R22]
            lower_q <= !want_up;
            hold_q  <= CNT_W'(MIN_PULSE_CYC);                 // [R3]
        end
    end
endmodule : phase_pwm
`default_nettype wire

/* core/gate_ctrl.sv */
// Purpose: Controller driving a three-phase gate driver through its pins
// Assumes: 200 MHz clock; fault line is open-drain with external pull-up
// Notes:   Registers are plain ports; no bus
// Summary of operation
// (R1) High command level turns its switch on
// (R2) Insert at least 1.5 us dead time
// (R3) Every command pulse at least 0.5 us; enable going low ends a pulse early
// (R4) Carrier no faster than 20 kHz
// (R5) Command outputs always actively driven
// (R6) Strap low: device holds 8 ms; bench model holds 16000 cycles, 80 us
// (R7) Strap high: device holds 34 us
// (R8) Device pulls fault line on protections
// (R9) Low fault line forces lower switches off
// (R10) Device releases fault after hold time
// (R11) Idle device leaves fault line released
// (R12) Fault line is interrupt; stop all phases
// (R13) Silence all commands within hold time
// (R14) Budget 20 us to silence commands
// (R15) Wait two seconds before restarting
// (R16) Shutdown request forces lower switches off
// (R17) Shutdown levels last at least 3 us
// (R18) Reduce or stop drive when hot
// (R19) Upper gate follows command edges
// (R20) Overcurrent needs 0.5 us blanking
// (R21) Overvoltage holds fault 31 us more
// (R22) Never both commands; all low at reset
// (R23) Synchronise fault, latch until cleared
`timescale 1ns/100ps
`default_nettype none
module gate_ctrl
    import gate_ctrl_pkg::*;
#(
    parameter int     PERIOD_CYC  = MIN_PERIOD_CYC,      // Carrier period in cycles
    parameter longint RESTART_CNT = RESTART_CYC,         // Restart wait in cycles
    parameter int     REACT_CNT   = REACT_CYC            // Silencing deadline
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire logic                   run_req,
    input  wire logic                   shutdown_req,
    input  wire logic                   over_temp,
    input  wire logic                   fault_clear,
    input  wire logic [PHASES*DUTY_W-1:0] duty,
    input  wire logic                   fault_shutdown_line_in,
    output logic                        fault_shutdown_line_out,
    output logic                        fault_shutdown_line_oe,
    output gate_cmd_t                   cmd,
    output logic                        fault_flag,
    output logic                        running,
    output logic                        restart_ready,
    output logic                        react_late
);
    localparam int CW = 16;                              // Carrier counter width

    ctrl_state_t      state_q, state_d;                  // Controller state
    logic             fsync1_q, fsync2_q, fprev_q;       // Fault line synchroniser
    logic             fault_q;                           // Sticky fault event
    logic [CW-1:0]    carrier_q;                         // Shared carrier count
    logic [63:0]      wait_q;                            // Restart wait counter
    logic [31:0]      react_q;                           // Silencing deadline counter
    logic [31:0]      sd_q;                              // Shutdown level timer
    logic             sd_drive_q;                        // Shutdown pull active
    logic             fault_fall;                        // Falling edge seen
    logic             pwm_en;                            // Phases allowed to switch
    logic             line_low;                          // Synchronised low level
    logic [PHASES-1:0] up_w, lo_w;                       // Phase outputs

    // Width-safe carrier limit
    function automatic logic [CW-1:0] lim(input int v);
        lim = CW'(v - 1);
    endfunction : lim

    assign line_low   = !fsync2_q;
    assign fault_fall = fprev_q && !fsync2_q;            // Edge from synced copy only [R23]
    assign pwm_en     = (state_q == ST_RUN) && !line_low && !over_temp; // [R12] [R18]

    // Two-flop synchroniser; first flop read only by second
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fsync1_q <= 1'b1;
            fsync2_q <= 1'b1;
            fprev_q  <= 1'b1;
        end else begin
            fsync1_q <= fault_shutdown_line_in;          // [R23]
            fsync2_q <= fsync1_q;
            fprev_q  <= fsync2_q;
        end
    end

    // Sticky fault; set wins over clear. Our own shutdown pull is not a fault.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fault_q <= 1'b0;
        end else if (fault_fall && !sd_drive_q) begin
            fault_q <= 1'b1;                             // [R23] [R12]
        end else if (fault_clear) begin
            fault_q <= 1'b0;
        end
    end

    // Carrier sawtooth, period never under 50 us
    always_ff @(posedge clock) begin
        if (!rst_b || carrier_q >= lim(PERIOD_CYC)) begin
            carrier_q <= '0;                             // [R4]
        end else begin
            carrier_q <= carrier_q + 1'b1;
        end
    end

    // Next-state selection
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (run_req && !fault_q) state_d = ST_RUN;
            ST_RUN:   if (fault_q) state_d = ST_FAULT;   // [R12]
                      else if (!run_req) state_d = ST_IDLE;
            ST_FAULT: state_d = ST_WAIT;                 // Commands already dropped [R13]
            ST_WAIT:  if (wait_q == '0 && !fault_q) state_d = ST_IDLE; // [R15]
            default:  state_d = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Restart wait loads in the fault state and counts down from the edge that leaves it
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wait_q <= '0;
        end else if (state_q == ST_FAULT) begin
            wait_q <= 64'(RESTART_CNT);                  // [R15]
        end else if (wait_q != '0) begin
            wait_q <= wait_q - 1'b1;
        end
    end

    // Deadline watch: commands must be silent within 20 us of fault
    always_ff @(posedge clock) begin
        if (!rst_b || !line_low) begin
            react_q    <= '0;
            react_late <= 1'b0;
        end else begin
            if (react_q < 32'(REACT_CNT)) begin
                react_q <= react_q + 1'b1;
            end
            if (react_q == 32'(REACT_CNT) && (cmd != '0)) begin
                react_late <= 1'b1;                      // [R14]
            end
        end
    end

    // Shutdown request: each level held at least 3 us
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sd_drive_q <= 1'b0;
            sd_q       <= '0;
        end else if (sd_q != '0) begin
            sd_q <= sd_q - 1'b1;                         // [R17]
        end else if (shutdown_req != sd_drive_q) begin
            sd_drive_q <= shutdown_req;                  // [R16]
            sd_q       <= 32'(SD_LEVEL_CYC);             // [R17]
        end
    end

    // Open-drain: only ever pull low
    assign fault_shutdown_line_out = 1'b0;
    assign fault_shutdown_line_oe  = sd_drive_q;

    // Three phases sharing the carrier
    genvar g;
    generate
        for (g = 0; g < PHASES; g++) begin : g_phase
            phase_pwm #(
                .CNT_W   (CW)
            ) u_phase (
                .clock   (clock),
                .rst_b   (rst_b),
                .enable  (pwm_en),
                .carrier (carrier_q),
                .duty    (duty[g*DUTY_W +: DUTY_W]),
                .upper_q (up_w[g]),
                .lower_q (lo_w[g])
            );
        end
    endgenerate

    // Outputs driven from flops in the phases, never floating
    assign cmd.upper_switch_command = up_w;              // [R1] [R5]
    assign cmd.lower_switch_command = lo_w;              // [R1] [R5]
    assign fault_flag    = fault_q;
    assign running       = (state_q == ST_RUN);
    assign restart_ready = (state_q == ST_IDLE) && !fault_q;
endmodule : gate_ctrl
`default_nettype wire

/* bench/gate_ctrl_checker.sv */
// Purpose: Port timing checks for gate_ctrl
// Assumes: One clock, synchronous active-low reset
// Notes:   Counters start saturated so reset is no event
`timescale 1ns/100ps
`default_nettype none
module gate_ctrl_checker
    import gate_ctrl_pkg::*;
#(
    parameter longint RESTART_CNT = RESTART_CYC  // Restart wait
) (
    input wire logic      clock,
    input wire logic      rst_b,
    input wire logic      fault_shutdown_line_in,
    input wire logic      fault_shutdown_line_oe,
    input wire gate_cmd_t cmd,
    input wire logic      fault_flag,
    input wire logic      running
);
    logic [31:0] lvl_q;   // Cycles oe held its level
    logic [31:0] gap_q;   // Cycles since a fault rose
    logic [31:0] dead_q;  // Cycles phase 0 all low
    logic        oe_q;    // Oe one cycle back
    logic        flag_q;  // Flag one cycle back
    wire         busy0 = cmd.upper_switch_command[0] | cmd.lower_switch_command[0];
    // Saturating span counters
    always_ff @(posedge clock) begin
        oe_q   <= rst_b & fault_shutdown_line_oe;
        flag_q <= rst_b & fault_flag;
        lvl_q  <= !rst_b ? '1 : (oe_q != fault_shutdown_line_oe) ? 32'h1 : lvl_q + 32'(~&lvl_q);
        gap_q  <= !rst_b ? '1 : (fault_flag & ~flag_q) ? '0 : gap_q + 32'(~&gap_q);
        dead_q <= !rst_b ? '1 : busy0 ? '0 : dead_q + 32'(~&dead_q);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_no_shoot_through: assert property (~|(cmd.upper_switch_command & cmd.lower_switch_command))
        else $error("both commands of a phase high");
    a_fault_silences: assert property ($fell(fault_shutdown_line_in) && !fault_shutdown_line_oe |-> ##3 cmd == '0)
        else $error("commands not silenced after fault");
    a_flag_sets: assert property ($fell(fault_shutdown_line_in) && !fault_shutdown_line_oe |-> ##3 fault_flag)
        else $error("fault not latched");
    a_run_refused: assert property ($past(fault_flag, 2) && fault_flag |-> !running)
        else $error("running during fault");
    a_restart_gap: assert property ($rose(running) |-> gap_q >= RESTART_CNT)
        else $error("restart too soon");
    a_idle_quiet: assert property (!running && !$past(running) |-> cmd == '0)
        else $error("commands while stopped");
    a_dead_gap: assert property ($rose(busy0) |-> dead_q >= DEAD_CYC)
        else $error("dead time too short");
    a_level_span: assert property ($changed(fault_shutdown_line_oe) |-> lvl_q >= SD_LEVEL_CYC)
        else $error("shutdown level too short");
    c_fault: cover property ($rose(fault_flag));
    c_restart: cover property ($rose(running) && gap_q != '1);
    c_shutdown: cover property ($rose(fault_shutdown_line_oe));
endmodule : gate_ctrl_checker
bind gate_ctrl gate_ctrl_checker #(.RESTART_CNT(RESTART_CNT)) gate_ctrl_checker_i (
    .clock(clock), .rst_b(rst_b), .fault_shutdown_line_in(fault_shutdown_line_in),
    .fault_shutdown_line_oe(fault_shutdown_line_oe), .cmd(cmd),
    .fault_flag(fault_flag), .running(running));
`default_nettype wire

/* bench/inverter_device_model.sv */
// Purpose: Behavioural gate driver facing the controller
// Assumes: Times in clock cycles
// Notes:   Long hold scaled down from 8 ms to keep runs short
`timescale 1ns/100ps
`default_nettype none
module inverter_device_model
    import gate_ctrl_pkg::*;
#(
    parameter int HOLD_LONG  = 16000,  // Strap low hold, scaled
    parameter int HOLD_SHORT = 6800,   // Strap high hold, 34 us
    parameter int OV_HOLD    = 6200,   // Overvoltage extra hold
    parameter int BLANK      = 100     // Trip blanking, 0.5 us
) (
    input  wire logic       clock,
    input  wire gate_cmd_t  cmd,
    input  wire logic       fault_shutdown_line,
    input  wire logic       over_current,
    input  wire logic       over_voltage,
    input  wire logic       lower_supply_undervoltage,
    input  wire logic       hold_select,
    output logic            fault_pulldown_switch,
    output logic [2:0]      upper_gate_drive,
    output logic [2:0]      lower_gate_drive
);
    int         blank_q = 0;  // Cycles over trip
    int         oc_q = 0;     // Overcurrent hold left
    int         ov_q = 0;     // Overvoltage hold left
    logic [2:0] up_q = '0;    // Upper command one cycle back
    logic [2:0] hi_q = '0;    // Upper latch
    // Protections and the edge-driven upper latch
    always @(posedge clock) begin
        blank_q <= over_current ? blank_q + 1 : 0;
        if (over_current && blank_q == BLANK - 1)
            oc_q <= hold_select ? HOLD_SHORT : HOLD_LONG;
        else if (oc_q > 0)
            oc_q <= oc_q - 1;
        ov_q <= over_voltage ? OV_HOLD : (ov_q > 0 ? ov_q - 1 : 0);
        up_q <= cmd.upper_switch_command;
        hi_q <= (hi_q | (cmd.upper_switch_command & ~up_q)) & ~(up_q & ~cmd.upper_switch_command);
    end
    assign fault_pulldown_switch = oc_q > 0 || ov_q > 0 || lower_supply_undervoltage;
    assign upper_gate_drive = hi_q;
    assign lower_gate_drive = cmd.lower_switch_command & {3{fault_shutdown_line}};
endmodule : inverter_device_model
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench for gate_ctrl with a device model
// Assumes: 200 MHz clock, shortened restart wait
// Notes:   Outputs sampled on falling edges, inputs driven on rising
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import gate_ctrl_pkg::*;
    localparam longint RESTART_CNT = 1000;  // Shortened restart wait
    logic clock = 0, rst_b = 0, run_req = 0, shutdown_req = 0, over_temp = 0, fault_clear = 0;
    logic oc = 0, ov = 0, uv = 0, sel = 0, out_w, oe, fault_flag, running, react_late, pull;
    logic ready, prev_up;  // Restart-ready output; upper command one sample back
    logic [47:0] duty = '0;
    logic [2:0] hi, lo;
    gate_cmd_t cmd;
    int fail_count = 0, checks = 0, n, rises;
    wire fault_line = (oe ? out_w : 1'b1) & ~pull;  // Pull-up wins when released
    always #2.5 clock = ~clock;
    gate_ctrl #(.RESTART_CNT(RESTART_CNT)) gate_ctrl_i (.clock(clock), .rst_b(rst_b),
        .run_req(run_req), .shutdown_req(shutdown_req), .over_temp(over_temp),
        .fault_clear(fault_clear), .duty(duty), .fault_shutdown_line_in(fault_line),
        .fault_shutdown_line_out(out_w), .fault_shutdown_line_oe(oe), .cmd(cmd),
        .fault_flag(fault_flag), .running(running), .restart_ready(ready), .react_late(react_late));
    inverter_device_model inverter_device_model_i (.clock(clock), .cmd(cmd),
        .fault_shutdown_line(fault_line), .over_current(oc), .over_voltage(ov),
        .lower_supply_undervoltage(uv), .hold_select(sel), .fault_pulldown_switch(pull),
        .upper_gate_drive(hi), .lower_gate_drive(lo));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Expected low span of the line per cause
    function automatic int span(input int c);
        return c == 0 ? 16000 : c == 1 ? 6800 : c == 2 ? 4 + 6200 : 4;
    endfunction : span
    task automatic summarize();
        if (fail_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        summarize();
    end
    initial begin
        void'($urandom(32'h28999d19));
        repeat (16) @(posedge clock);
        rst_b <= 1;
        @(negedge clock);
        chk({cmd, oe, fault_flag, ready}, 9'h001);
        @(posedge clock);
        duty <= {16'h0000, 16'($urandom_range(9500, 500)), 16'($urandom_range(9500, 500))};
        run_req <= 1;
        repeat (2000) @(negedge clock);
        rises = 0;
        prev_up = cmd.upper_switch_command[0];
        for (int i = 0; i < 10000; i++) begin
            @(negedge clock);
            rises += int'(cmd.upper_switch_command[0] && !prev_up);
            prev_up = cmd.upper_switch_command[0];
        end
        chk(rises, 1);
        @(posedge clock) over_temp <= 1;
        repeat (400) @(negedge clock);
        chk({cmd, hi}, 9'h000);
        @(posedge clock) over_temp <= 0;
        shutdown_req <= 1;
        for (n = 0; n < 2000 && fault_line; n++) @(negedge clock);
        chk(lo, 3'h0);
        @(posedge clock) shutdown_req <= 0;
        for (n = 0; n < 5000 && !fault_line; n++) @(negedge clock);
        chk(n >= SD_LEVEL_CYC - 1, 1'b1);
        for (int c = 0; c < 4; c++) begin
            repeat ($urandom_range(3000, 1200)) @(posedge clock);
            sel <= c[0];
            oc <= c < 2;
            ov <= c == 2;
            uv <= c == 3;
            for (n = 0; n < 300 && fault_line; n++) @(negedge clock);
            repeat (3) @(negedge clock);
            chk({cmd, fault_flag, lo}, 10'h008);
            @(posedge clock) {oc, ov, uv} <= 3'h0;
            for (n = 3; n < 20000 && !fault_line; n++) @(negedge clock);
            chk({running, react_late, 32'(n)}, {2'b00, 32'(span(c))});
            @(posedge clock) fault_clear <= 1;
            @(posedge clock) fault_clear <= 0;
            for (n = 0; n < 3000 && !running; n++) @(negedge clock);
            chk({fault_flag, running}, 2'b01);
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
